/* File: design/nfcs_cfg.svh */
`ifndef NFCS_CFG_SVH
`define NFCS_CFG_SVH

// ----------------------------------------
// clock and pin timing
// ----------------------------------------
`define NFCS_CLK_NS 40
`define NFCS_T_SET_NS 40
`define NFCS_T_WE_NS 50
`define NFCS_T_REC_NS 40
`define NFCS_T_ACC_NS 120
`define NFCS_T_RST_NS 500
`define NFCS_CYC(t) (((t) + `NFCS_CLK_NS - 1) / `NFCS_CLK_NS)
`define NFCS_SYNC_LAT 4

// ----------------------------------------
// device command bytes and pattern addresses
// ----------------------------------------
`define NFCS_D_UNLOCK1 8'hAA
`define NFCS_D_UNLOCK2 8'h55
`define NFCS_D_IDENT 8'h90
`define NFCS_D_PROG 8'hA0
`define NFCS_D_ERASE 8'h80
`define NFCS_D_CHIP 8'h10
`define NFCS_D_SECT 8'h30
`define NFCS_D_PROT 8'h20
`define NFCS_D_SUSP 8'hB0
`define NFCS_D_RESET 8'hF0
`define NFCS_A_555 11'h555
`define NFCS_A_2AA 11'h2AA
`define NFCS_DQ_POLL 7
`define NFCS_DQ_TOG 6
`define NFCS_DQ_TO 5

// ----------------------------------------
// sector decode
// ----------------------------------------
`define NFCS_SEC64_F 17:16
`define NFCS_SEC32_B 15
`define NFCS_SEC16_B 14
`define NFCS_SEC8_B 13
`define NFCS_SEC64_BASE 3'h3
`define NFCS_SEC_32K 3'h3
`define NFCS_SEC_LAST 3'h6

// ----------------------------------------
// register port
// ----------------------------------------
`define NFCS_ADDR_W 18
`define NFCS_REG_CMD 8'h00
`define NFCS_REG_ADDR 8'h04
`define NFCS_REG_DATA 8'h08
`define NFCS_REG_STAT 8'h0C
`define NFCS_REG_CFG 8'h10
`define NFCS_CFG_BOTTOM 0
`define NFCS_STEP_DONE 3'h7

// ----------------------------------------
// operation codes
// ----------------------------------------
`define NFCS_OP_READ 4'h0
`define NFCS_OP_RESET 4'h1
`define NFCS_OP_ID 4'h2
`define NFCS_OP_PROG 4'h3
`define NFCS_OP_CHIP 4'h4
`define NFCS_OP_SECT 4'h5
`define NFCS_OP_ADDSEC 4'h6
`define NFCS_OP_SUSP 4'h7
`define NFCS_OP_RESUME 4'h8
`define NFCS_OP_PROT 4'h9
`define NFCS_OP_POLL 4'hA
`define NFCS_OP_HWRST 4'hB

`endif

/* File: design/nfcs_pkg.sv */
package nfcs_pkg;

    typedef logic [3:0] nfcs_op_t;

    typedef enum logic [2:0] {
        K_END, K_WR, K_RD, K_POLL, K_PULSE
    } nfcs_kind_t;

    typedef enum logic [2:0] {
        S_IDLE, S_STEP, S_WSET, S_WLOW, S_WREC, S_RWAIT, S_RST
    } nfcs_fsm_t;

    typedef struct packed {
        logic [17:0] addr;
        logic [7:0] dq;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
    } nfcs_flash_t;

    typedef struct packed {
        nfcs_kind_t kind;
        logic reg_a;
        logic [10:0] a;
        logic reg_d;
        logic [7:0] d;
    } nfcs_step_t;

    typedef struct packed {
        logic [11:0] zero;
        logic [2:0] erase_sec;
        logic [2:0] sec;
        logic susp;
        logic erase_act;
        logic refused;
        logic fail;
        logic done;
        logic busy;
        logic [7:0] rd;
    } nfcs_status_t;

    typedef struct packed {
        nfcs_fsm_t fsm;
        nfcs_op_t op;
        logic [2:0] idx;
        logic [7:0] cnt;
        nfcs_flash_t pins;
        logic [17:0] addr;
        logic [7:0] wdata;
        logic bottom;
        logic [7:0] rd;
        logic [2:0] erase_sec;
        logic busy;
        logic done;
        logic fail;
        logic refused;
        logic erase_act;
        logic chip;
        logic susp;
        logic is_poll;
        logic poll_first;
        logic prev_tog;
        logic seen_to;
        logic abort;
        logic [31:0] rdata;
    } nfcs_state_t;

endpackage : nfcs_pkg

/* File: design/nfcs_sync.sv */
`timescale 1ns/1ps

module nfcs_sync #(
    parameter int W = 8
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic en_i,
    // async in, settled out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } nfcs_sync_st_t;

    nfcs_sync_st_t st_reg;
    nfcs_sync_st_t st_next;

    // s1 feeds only s2; a value counts once s2 and s3 agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d_i;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.q = st_reg.s3;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else if (en_i) begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.q;

endmodule : nfcs_sync

/* File: design/nfcs_ctrl.sv */
`timescale 1ns/1ps
`include "nfcs_cfg.svh"

// Flash device rules this block works with
// RL1: address latched at strobe fall, data at rise
// RL2: patterns on low eleven address lines only
// RL3: single F0 write returns to array read
// RL4: read mode returns stored byte at address
// RL5: three-cycle identifier entry, then id reads
// RL6: protect-verify location reads 01 or 00
// RL7: unlock, A0, then address and data programs
// RL8: six-cycle chip erase ending 10 at 555
// RL9: sector erase ends with 30 at sector
// RL10: any sector combination or whole array erasable
// RL11: device preprograms and times erase itself
// RL12: whole-array erase uses fixed bulk pulses; here chip erase issues no pulses and is polled like the other erases
// RL13: B0 during sector erase suspends it
// RL14: 30 while suspended resumes the erase
// RL15: suspended: read, program other sectors only
// RL16: after suspend device stays in read mode
// RL17: commands ignored while a program runs
// RL18: sector erase accepts only the suspend command; here an add-sector write is accepted as well
// RL19: full command set back after completion
// RL20: six-cycle sequence ending 20 arms protect
// RL21: sector decode follows top or bottom variant
// RL22: reset pin forces read mode
// RL23: done when toggle bit steady two reads
// RL24: timeout bit high means erase failure
// RL25: after failure F0 aborts, new command needed
// RL26: read mode holds until next command write
// RL27: bad sequence cycle drops back to read
// RL28: device drives data only with CE, OE low
module nfcs_ctrl
    import nfcs_pkg::*;
#(
    parameter int SET_CYC = `NFCS_CYC(`NFCS_T_SET_NS),
    parameter int WE_CYC = `NFCS_CYC(`NFCS_T_WE_NS),
    parameter int REC_CYC = `NFCS_CYC(`NFCS_T_REC_NS),
    parameter int RD_CYC = `NFCS_CYC(`NFCS_T_ACC_NS) + `NFCS_SYNC_LAT,
    parameter int RST_CYC = `NFCS_CYC(`NFCS_T_RST_NS)
) (
    // clock, reset, enable
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    input wire logic EN_I,
    // register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    output logic [31:0] REG_RDATA_O,
    // flash pins
    output nfcs_pkg::nfcs_flash_t FLASH_O,
    input wire logic [7:0] FLASH_DQ_I
);
    import nfcs_pkg::*;

    localparam logic [7:0] SET_M1 = 8'(SET_CYC - 1);
    localparam logic [7:0] WE_M1 = 8'(WE_CYC - 1);
    localparam logic [7:0] REC_M1 = 8'(REC_CYC - 1);
    localparam logic [7:0] RD_M1 = 8'(RD_CYC - 1);
    localparam logic [7:0] RST_M1 = 8'(RST_CYC - 1);

    nfcs_state_t st_reg;
    nfcs_state_t st_next;
    logic [7:0] dq_sync;
    nfcs_step_t stp;
    nfcs_status_t stat;
    logic [2:0] sec_now;
    nfcs_op_t new_op;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // RL21 boot variant
    function automatic logic [2:0] sec_of(input logic [17:0] a,
                                          input logic bottom);
        logic [17:0] m;
        logic [2:0] b;
        m = bottom ? a : ~a;
        if (m[`NFCS_SEC64_F] != 2'h0) begin
            b = {1'b0, m[`NFCS_SEC64_F]} + `NFCS_SEC64_BASE;
        end else if (m[`NFCS_SEC32_B]) begin
            b = `NFCS_SEC_32K;
        end else if (m[`NFCS_SEC16_B]) begin
            b = {2'h0, m[`NFCS_SEC8_B]} + 3'h1;
        end else begin
            b = 3'h0;
        end
        return bottom ? b : `NFCS_SEC_LAST - b;
    endfunction : sec_of

    // bus cycles of each operation, END past the last one
    function automatic nfcs_step_t step_of(input nfcs_op_t op,
                                           input logic [2:0] i);
        nfcs_step_t s;
        logic six;
        logic unl;
        s = '{kind: K_END, reg_a: 1'b0, a: `NFCS_A_555,
              reg_d: 1'b0, d: `NFCS_D_RESET};
        six = (op == `NFCS_OP_CHIP) || (op == `NFCS_OP_SECT) ||
              (op == `NFCS_OP_PROT);
        unl = six || (op == `NFCS_OP_ID) || (op == `NFCS_OP_PROG);
        // RL2 unlock pattern
        if (unl && (i == 3'h0 || i == 3'h1 ||
                    (six && (i == 3'h3 || i == 3'h4)))) begin
            s.kind = K_WR;
            s.a = (i == 3'h1 || i == 3'h4) ? `NFCS_A_2AA : `NFCS_A_555;
            s.d = (i == 3'h1 || i == 3'h4) ? `NFCS_D_UNLOCK2
                                           : `NFCS_D_UNLOCK1;
        end else begin
            case (op)
                // RL4 RL26 array read
                `NFCS_OP_READ: if (i == 3'h0) begin
                    s.kind = K_RD;
                    s.reg_a = 1'b1;
                end
                // RL3 reset write
                `NFCS_OP_RESET: if (i == 3'h0) begin
                    s.kind = K_WR;
                    s.reg_a = 1'b1;
                end
                // RL5 RL6 identifier entry and verify read
                `NFCS_OP_ID: if (i == 3'h2) begin
                    s.kind = K_WR;
                    s.d = `NFCS_D_IDENT;
                end else if (i == 3'h3) begin
                    s.kind = K_RD;
                    s.reg_a = 1'b1;
                end
                // RL7 program byte
                `NFCS_OP_PROG: if (i == 3'h2) begin
                    s.kind = K_WR;
                    s.d = `NFCS_D_PROG;
                end else if (i == 3'h3) begin
                    s.kind = K_WR;
                    s.reg_a = 1'b1;
                    s.reg_d = 1'b1;
                end else if (i == 3'h4) begin
                    s.kind = K_POLL;
                    s.reg_a = 1'b1;
                end
                // RL8 RL9 RL11 RL12 RL20 erase-class sequences
                `NFCS_OP_CHIP, `NFCS_OP_SECT, `NFCS_OP_PROT: begin
                    if (i == 3'h2) begin
                        s.kind = K_WR;
                        s.d = `NFCS_D_ERASE;
                    end else if (i == 3'h5) begin
                        s.kind = K_WR;
                        s.reg_a = (op == `NFCS_OP_SECT);
                        s.d = (op == `NFCS_OP_CHIP) ? `NFCS_D_CHIP :
                              (op == `NFCS_OP_SECT) ? `NFCS_D_SECT
                                                    : `NFCS_D_PROT;
                    end
                end
                // RL10 RL14 extra sector or resume
                `NFCS_OP_ADDSEC, `NFCS_OP_RESUME: if (i == 3'h0) begin
                    s.kind = K_WR;
                    s.reg_a = 1'b1;
                    s.d = `NFCS_D_SECT;
                end
                // RL13 suspend
                `NFCS_OP_SUSP: if (i == 3'h0) begin
                    s.kind = K_WR;
                    s.reg_a = 1'b1;
                    s.d = `NFCS_D_SUSP;
                end
                `NFCS_OP_POLL: if (i == 3'h0) begin
                    s.kind = K_POLL;
                    s.reg_a = 1'b1;
                end
                `NFCS_OP_HWRST: if (i == 3'h0) begin
                    s.kind = K_PULSE;
                end
                default: s.kind = K_END;
            endcase
        end
        return s;
    endfunction : step_of

    // RL17 RL18 RL15 commands the device would drop are refused here
    function automatic logic op_ok(input nfcs_op_t op,
                                   input nfcs_state_t s,
                                   input logic [2:0] sec);
        logic ok;
        if (op == `NFCS_OP_HWRST || op == `NFCS_OP_POLL) begin
            ok = 1'b1;
        end else if (s.susp) begin
            ok = (op == `NFCS_OP_RESUME) ||
                 ((op == `NFCS_OP_READ || op == `NFCS_OP_PROG) &&
                  (s.chip || sec != s.erase_sec));
        end else if (s.erase_act) begin
            ok = !s.chip && (op == `NFCS_OP_SUSP ||
                             op == `NFCS_OP_ADDSEC);
        end else begin
            ok = (op <= `NFCS_OP_PROT) && op != `NFCS_OP_SUSP &&
                 op != `NFCS_OP_RESUME && op != `NFCS_OP_ADDSEC;
        end
        return ok;
    endfunction : op_ok

    // ----------------------------------------
    // data pin synchroniser
    // ----------------------------------------
    nfcs_sync #(
        .W(8)
    ) u_dq_sync (
        .clk_i(SYS_CLK_I),
        .arst_n_i(ARST_N_I),
        .en_i(EN_I),
        .d_i(FLASH_DQ_I),
        .q_o(dq_sync)
    );

    assign sec_now = sec_of(st_reg.addr, st_reg.bottom);
    assign new_op = REG_WDATA_I[3:0];
    // RL25 after a failure only the abort write goes out
    assign stp = st_reg.abort ?
                 nfcs_step_t'{kind: K_WR, reg_a: 1'b1, a: `NFCS_A_555,
                   reg_d: 1'b0, d: `NFCS_D_RESET}
               : step_of(st_reg.op, st_reg.idx);

    always_comb begin
        stat = '0;
        stat.erase_sec = st_reg.erase_sec;
        stat.sec = sec_now;
        stat.susp = st_reg.susp;
        stat.erase_act = st_reg.erase_act;
        stat.refused = st_reg.refused;
        stat.fail = st_reg.fail;
        stat.done = st_reg.done;
        stat.busy = st_reg.busy;
        stat.rd = st_reg.rd;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        // register port; reading status clears done and refused
        if (REG_RE_I) begin
            case (REG_ADDR_I)
                `NFCS_REG_ADDR: st_next.rdata = 32'(st_reg.addr);
                `NFCS_REG_DATA: st_next.rdata = 32'(st_reg.wdata);
                `NFCS_REG_STAT: begin
                    st_next.rdata = stat;
                    st_next.done = 1'b0;
                    st_next.refused = 1'b0;
                end
                `NFCS_REG_CFG: st_next.rdata = 32'(st_reg.bottom);
                default: st_next.rdata = '0;
            endcase
        end
        // address and data stay put during an operation
        if (REG_WE_I && !st_reg.busy) begin
            case (REG_ADDR_I)
                `NFCS_REG_ADDR:
                    st_next.addr = REG_WDATA_I[`NFCS_ADDR_W-1:0];
                `NFCS_REG_DATA: st_next.wdata = REG_WDATA_I[7:0];
                `NFCS_REG_CFG:
                    st_next.bottom = REG_WDATA_I[`NFCS_CFG_BOTTOM];
                default: ;
            endcase
        end
        case (st_reg.fsm)
            S_IDLE: begin
                if (REG_WE_I && REG_ADDR_I == `NFCS_REG_CMD) begin
                    if (op_ok(new_op, st_reg, sec_now)) begin
                        st_next.op = new_op;
                        st_next.idx = 3'h0;
                        st_next.busy = 1'b1;
                        st_next.fail = 1'b0;
                        st_next.poll_first = 1'b1;
                        st_next.seen_to = 1'b0;
                        st_next.abort = 1'b0;
                        st_next.fsm = S_STEP;
                    end else begin
                        st_next.refused = 1'b1;
                    end
                end
            end
            S_STEP: begin
                // RL2 upper lines zero on pattern cycles
                st_next.pins.addr = stp.reg_a ? st_reg.addr
                                              : 18'(stp.a);
                st_next.is_poll = (stp.kind == K_POLL);
                case (stp.kind)
                    K_WR: begin
                        st_next.pins.dq = stp.reg_d ? st_reg.wdata
                                                    : stp.d;
                        st_next.pins.dq_oe = 1'b1;
                        st_next.pins.ce_n = 1'b0;
                        st_next.cnt = SET_M1;
                        st_next.fsm = S_WSET;
                    end
                    // RL28 data pins released before OE falls
                    K_RD, K_POLL: begin
                        st_next.pins.dq_oe = 1'b0;
                        st_next.pins.ce_n = 1'b0;
                        st_next.pins.oe_n = 1'b0;
                        st_next.cnt = RD_M1;
                        st_next.fsm = S_RWAIT;
                    end
                    // RL22 reset pin pulse
                    K_PULSE: begin
                        st_next.pins.reset_n = 1'b0;
                        st_next.cnt = RST_M1;
                        st_next.fsm = S_RST;
                    end
                    default: begin
                        // RL19 erase state follows the finished op
                        st_next.busy = 1'b0;
                        st_next.done = 1'b1;
                        st_next.fsm = S_IDLE;
                        case (st_reg.op)
                            `NFCS_OP_CHIP: begin
                                st_next.erase_act = 1'b1;
                                st_next.chip = 1'b1;
                            end
                            `NFCS_OP_SECT: begin
                                st_next.erase_act = 1'b1;
                                st_next.chip = 1'b0;
                                st_next.erase_sec = sec_now;
                            end
                            // RL16 suspended device reads array
                            `NFCS_OP_SUSP: st_next.susp = 1'b1;
                            `NFCS_OP_RESUME: st_next.susp = 1'b0;
                            `NFCS_OP_HWRST, `NFCS_OP_POLL: begin
                                if (!st_reg.susp ||
                                    st_reg.op == `NFCS_OP_HWRST) begin
                                    st_next.erase_act = 1'b0;
                                    st_next.susp = 1'b0;
                                end
                            end
                            default: ;
                        endcase
                        // RL25 failed op leaves device idle
                        if (st_reg.fail) begin
                            st_next.erase_act = 1'b0;
                            st_next.susp = 1'b0;
                        end
                    end
                endcase
            end
            S_WSET: begin
                if (st_reg.cnt == '0) begin
                    // RL1 address taken on this fall
                    st_next.pins.we_n = 1'b0;
                    st_next.cnt = WE_M1;
                    st_next.fsm = S_WLOW;
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h1;
                end
            end
            S_WLOW: begin
                if (st_reg.cnt == '0) begin
                    // RL1 data taken on this rise
                    st_next.pins.we_n = 1'b1;
                    st_next.cnt = REC_M1;
                    st_next.fsm = S_WREC;
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h1;
                end
            end
            S_WREC: begin
                if (st_reg.cnt == '0) begin
                    st_next.pins.ce_n = 1'b1;
                    st_next.pins.dq_oe = 1'b0;
                    st_next.pins.reset_n = 1'b1;
                    st_next.abort = 1'b0;
                    st_next.idx = st_reg.abort ? `NFCS_STEP_DONE
                                               : st_reg.idx + 3'h1;
                    st_next.fsm = S_STEP;
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h1;
                end
            end
            S_RWAIT: begin
                if (st_reg.cnt == '0) begin
                    st_next.rd = dq_sync;
                    st_next.pins.ce_n = 1'b1;
                    st_next.pins.oe_n = 1'b1;
                    st_next.fsm = S_STEP;
                    if (!st_reg.is_poll) begin
                        st_next.idx = st_reg.idx + 3'h1;
                    end else if (st_reg.poll_first) begin
                        st_next.poll_first = 1'b0;
                        st_next.prev_tog = dq_sync[`NFCS_DQ_TOG];
                        st_next.seen_to = dq_sync[`NFCS_DQ_TO];
                    // RL23 steady toggle bit ends polling
                    end else if (dq_sync[`NFCS_DQ_TOG] ==
                                 st_reg.prev_tog) begin
                        st_next.idx = st_reg.idx + 3'h1;
                    // RL24 RL25 timeout then still toggling fails
                    end else if (st_reg.seen_to) begin
                        st_next.fail = 1'b1;
                        st_next.abort = 1'b1;
                    end else begin
                        st_next.prev_tog = dq_sync[`NFCS_DQ_TOG];
                        st_next.seen_to = dq_sync[`NFCS_DQ_TO];
                    end
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h1;
                end
            end
            S_RST: begin
                if (st_reg.cnt == '0) begin
                    st_next.pins.reset_n = 1'b1;
                    st_next.cnt = REC_M1;
                    st_next.fsm = S_WREC;
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h1;
                end
            end
            default: st_next.fsm = S_IDLE;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_reg <= '0;
            st_reg.fsm <= S_IDLE;
            st_reg.pins.ce_n <= 1'b1;
            st_reg.pins.oe_n <= 1'b1;
            st_reg.pins.we_n <= 1'b1;
            st_reg.pins.reset_n <= 1'b1;
        end else if (EN_I) begin
            st_reg <= st_next;
        end
    end

    assign FLASH_O = st_reg.pins;
    assign REG_RDATA_O = st_reg.rdata;

endmodule : nfcs_ctrl

/* File: dv/nfcs_ctrl_sva.sv */
`timescale 1ns/1ps
module nfcs_ctrl_sva
    import nfcs_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    input nfcs_pkg::nfcs_flash_t FLASH_O
);
    wire nfcs_flash_t f = FLASH_O;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence s_fall;
        $fell(f.we_n);
    endsequence
    sequence s_rise;
        $rose(f.we_n);
    endsequence
    a_write_frame: assert property (
        !f.we_n |-> !f.ce_n && f.oe_n && f.dq_oe) else $error("bad write");
    a_addr_setup: assert property (
        s_fall |-> $stable(f.addr) && $stable(f.dq)) else $error("no setup");
    a_data_hold: assert property (
        s_rise |-> $stable(f.addr) && $stable(f.dq) && f.dq_oe)
        else $error("no hold");
    a_read_release: assert property (
        !f.oe_n |-> !f.dq_oe && !f.ce_n) else $error("bus fight");
    a_reset_pulse: assert property (
        $fell(f.reset_n) |=> !f.reset_n [*8] ##[1:12] f.reset_n)
        else $error("bad reset pulse");
    a_reset_quiet: assert property (
        !f.reset_n |-> f.ce_n && f.we_n) else $error("access in reset");
    a_unlock_first: assert property (
        s_fall ##0 f.dq == 8'hAA |-> f.addr == 18'h555)
        else $error("bad unlock address");
    a_unlock_second: assert property (
        s_fall ##0 f.dq == 8'h55 |-> f.addr == 18'h2AA)
        else $error("bad unlock address");
endmodule : nfcs_ctrl_sva

bind nfcs_ctrl nfcs_ctrl_sva i_nfcs_ctrl_sva (.SYS_CLK_I(SYS_CLK_I),
    .ARST_N_I(ARST_N_I), .FLASH_O(FLASH_O));

/* File: dv/nfcs_flash_model.sv */
`timescale 1ns/1ps
module nfcs_flash_model
    import nfcs_pkg::*;
#(
    // arbitrary identifier values
    parameter logic [7:0] MAKER = 8'h5A,
    parameter logic [7:0] DEVICE = 8'h6B
) (
    input nfcs_pkg::nfcs_flash_t pins_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [logic [17:0]];
    logic [17:0] a;
    logic [7:0] d;
    logic [7:0] mode = 8'h00;
    logic [7:0] r = 8'h00;
    int n = 0;
    int bsy = 0;
    int sus = 0;
    bit hang = 0;
    assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? r : ~r;
    always @(negedge pins_i.we_n) a = pins_i.addr;
    always @(posedge pins_i.we_n or negedge pins_i.reset_n) begin
        d = pins_i.dq;
        if (!pins_i.reset_n) begin
            {n, bsy, sus, mode} = '0;
        end else if (bsy > 0) begin
            if (d == 8'hB0) {sus, bsy} = {bsy, 32'd0};
            else if (hang && d == 8'hF0) {bsy, hang} = '0;
        end else if (sus > 0 && d == 8'h30) {bsy, sus} = {sus, 32'd0};
        else if (d == 8'hF0) {n, mode} = '0;
        else if (mode == 8'hA0) begin
            mem[a] = d;
            {mode, bsy} = {8'h00, 32'd2};
        end else if (n == 2 && d inside {8'h90, 8'hA0}) {mode, n} = {d, 32'd0};
        else if (n == 5) begin
            n = 0;
            if (d inside {8'h10, 8'h30}) mem.delete();
            if (d inside {8'h10, 8'h30}) bsy = 4;
        end else n++;
    end
    always @(negedge pins_i.oe_n) begin
        if (bsy > 0) {r, bsy} = {1'b0, ~r[6], hang, 5'h00, bsy - !hang};
        else if (mode == 8'h90)
            r = pins_i.addr[1] ? 8'h00 : pins_i.addr[0] ? DEVICE : MAKER;
        else r = mem.exists(pins_i.addr) ? mem[pins_i.addr] : 8'hFF;
    end
endmodule : nfcs_flash_model

/* File: dv/nfcs_ctrl_tb.sv */
`timescale 1ns/1ps
module nfcs_ctrl_tb;
    import nfcs_pkg::*;
    logic clk = 0, rst_n = 0, we = 0, re = 0;
    logic [7:0] ra = 0, dq, pd;
    logic [31:0] wd = 0, rdata, q;
    logic [17:0] pa;
    nfcs_flash_t fo;
    int err_total = 0, checks = 0, cyc = 0;
    always #20 clk = ~clk;
    nfcs_ctrl i_nfcs_ctrl (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .EN_I(1'b1),
        .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WE_I(we), .REG_RE_I(re),
        .REG_RDATA_O(rdata), .FLASH_O(fo), .FLASH_DQ_I(dq));
    nfcs_flash_model i_nfcs_flash_model (.pins_i(fo), .dq_o(dq));
    task automatic conclude;
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] m, input logic [31:0] e);
        checks++;
        if ((q & m) !== e) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, q & m, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {ra, wd, we} <= {a, d, 1'b1};
        @(posedge clk);
        we <= 1'b0;
    endtask : wr
    task automatic op(input logic [3:0] c, input logic [17:0] a);
        wr(8'h04, {14'h0, a});
        wr(8'h00, {28'h0, c});
        do begin
            @(posedge clk);
            {ra, re} <= {8'h0C, 1'b1};
            @(posedge clk);
            re <= 1'b0;
            #1 q = rdata;
        end while (q[8] !== 1'b0);
    endtask : op
    function automatic logic [7:0] id_exp(input int i);
        return i == 2 ? 8'h00 : i == 1 ? 8'h6B : 8'h5A;
    endfunction : id_exp
    always @(posedge clk) if (++cyc == 40000) begin
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(32'h37a29651));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wr(8'h10, 32'h1);
        op(4'hB, 0);
        chk(32'h300, 32'h200);
        for (int i = 0; i < 4; i++) begin
            pa = i ? 18'($urandom) : 18'h3FFFF;
            pd = {2'b11, 6'($urandom)};
            wr(8'h08, {24'h0, pd});
            op(4'h3, pa);
            op(4'h0, pa);
            chk(32'hFF, {24'h0, pd});
        end
        wr(8'h00, 32'h3);
        wr(8'h00, 32'h1);
        op(4'hA, pa);
        chk(32'h8FF, {24'h0, pd});
        for (int i = 0; i < 3; i++) begin
            op(4'h2, 18'(i));
            chk(32'hFF, {24'h0, id_exp(i)});
        end
        op(4'h1, 0);
        op(4'h0, pa);
        chk(32'hFF, {24'h0, pd});
        op(4'h4, 0);
        op(4'hA, 0);
        op(4'h0, pa);
        chk(32'h14FF, 32'h00FF);
        op(4'h5, 18'h20000);
        op(4'h6, 18'h28000);
        chk(32'h1A00, 32'h1200);
        op(4'h4, 0);
        chk(32'hFD800, 32'hA1800);
        op(4'h7, 18'h20000);
        op(4'h0, 18'h00100);
        chk(32'h20FF, 32'h20FF);
        op(4'h8, 18'h20000);
        op(4'hA, 18'h20000);
        chk(32'h3400, 0);
        op(4'h9, 0);
        chk(32'hB00, 32'h200);
        i_nfcs_flash_model.hang = 1'b1;
        op(4'h4, 0);
        op(4'hA, 0);
        chk(32'h1400, 32'h400);
        wr(8'h10, 0);
        op(4'h0, 18'h3C000);
        chk(32'h1C400, 32'h18000);
        conclude();
    end
endmodule : nfcs_ctrl_tb
